// ---- axis_board.sv ----
// axis board end: position tracking, broadcast capture, register readout and module reset
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// Behaviour
// - broadcast address 000 captures all axes together
// - host then reads each axis position in turn
// - captured sample taken 80 ns before strobe
// - captured position valid 150 ns after strobe
// - host holds enable low at least 50 ns
// - host spaces axis accesses at least 100 ns
// - 4 MHz single axis, plus 100 ns per axis
// - four 36-bit registers decoded per board
// - first register returns captured 36-bit position
// - status: cosine bits 0-9, sine 10-19
// - status: strength 20-27, errors 28-31, switches 32-34
// - third register access resets this board only
// - third register at address 0 resets all
// - fourth register reserved, reads zero
// - board address taken from switches, seven axes
// - switch resolution scales count by power two
// - direction switch reverses count sense
// - 4096 subdivisions per period, 36-bit word
module axis_board (
	input wire logic clk_sys,
	input wire logic sys_rst,
	readout_bus_if.board bus,
	input wire logic [readout_pkg::ADC_W-1:0] cos_sample,
	input wire logic [readout_pkg::ADC_W-1:0] sin_sample,
	input wire logic [readout_pkg::PHASE_W-1:0] phase_fine,
	input wire logic [readout_pkg::STR_W-1:0] strength,
	input wire logic [1:0] err_ext,
	input wire logic [readout_pkg::AXIS_W-1:0] sw_addr,
	input wire logic [1:0] sw_res,
	input wire logic sw_dir,
	output logic module_reset,
	output logic position_valid
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int BUS_W = 1 + readout_pkg::AXIS_W + readout_pkg::REG_W;
	localparam int SW_W = 1 + 2 + readout_pkg::AXIS_W;
	localparam int DVC_W = 5;
	// the capture lands two cycles after the edge clears stage three, so those count too
	localparam logic [DVC_W-1:0] DV_LOAD =
		DVC_W'(readout_pkg::TDV_CYC - readout_pkg::SYNC_LAT - 2);

	logic [BUS_W-1:0] bus_s;
	logic [SW_W-1:0] sw_s;

	pin_sync #(.WIDTH(BUS_W), .INIT({BUS_W{1'b1}})) bus_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin({bus.enable_n, bus.sel_axis, bus.sel_reg}),
		.q(bus_s)
	);

	// switches are static straps but still arrive from outside the clock domain
	pin_sync #(.WIDTH(SW_W), .INIT({SW_W{1'b0}})) sw_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin({sw_dir, sw_res, sw_addr}),
		.q(sw_s)
	);

	logic enable_s;
	logic [readout_pkg::AXIS_W-1:0] axis_s, own_addr;
	logic [readout_pkg::REG_W-1:0] reg_s;
	logic [1:0] res_s;
	logic dir_s;
	assign enable_s = bus_s[BUS_W-1];
	assign axis_s = bus_s[BUS_W-2 -: readout_pkg::AXIS_W];
	assign reg_s = bus_s[readout_pkg::REG_W-1:0];
	assign own_addr = sw_s[readout_pkg::AXIS_W-1:0];
	assign res_s = sw_s[readout_pkg::AXIS_W +: 2];
	assign dir_s = sw_s[SW_W-1];

	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	logic en_prev_q, en_prev_d;
	logic fall, mine, bcast, capture_evt, reset_evt;

	// address 0 is the broadcast slot, so a board strapped to 0 never answers alone
	always_comb begin
		en_prev_d = enable_s;
		fall = en_prev_q & ~enable_s;
		mine = (axis_s == own_addr) && (own_addr != readout_pkg::BCAST_AXIS);
		bcast = (axis_s == readout_pkg::BCAST_AXIS);
		capture_evt = fall && bcast && (reg_s == readout_pkg::REG_POSITION);
		reset_evt = fall && (reg_s == readout_pkg::REG_MODRESET) && (mine || bcast);
	end

	// ----------------------------------------------------------------
	// position tracking
	// ----------------------------------------------------------------
	logic [readout_pkg::PHASE_W-1:0] prev_phase_q, prev_phase_d;
	logic [readout_pkg::PERIOD_W-1:0] period_q, period_d;
	logic [readout_pkg::POS_W-1:0] pos_q, pos_d;
	logic [3:0] err_q, err_d;
	logic [1:0] quad_prev, quad_cur;
	logic signed [readout_pkg::POS_W-1:0] raw_s, sense_s;
	logic [3:0] err_new;

	// quadrant steps mark period wraps; an opposite quadrant means the phase moved too far
	always_comb begin
		quad_prev = prev_phase_q[readout_pkg::PHASE_W-1 -: 2];
		quad_cur = phase_fine[readout_pkg::PHASE_W-1 -: 2];
		prev_phase_d = phase_fine;
		period_d = period_q;
		if (quad_prev == 2'h3 && quad_cur == 2'h0) begin
			period_d = period_q + 1'b1;
		end else if (quad_prev == 2'h0 && quad_cur == 2'h3) begin
			period_d = period_q - 1'b1;
		end
		if (reset_evt) begin
			period_d = '0;
		end
		raw_s = {period_q, prev_phase_q};
		sense_s = dir_s ? -raw_s : raw_s;
		pos_d = sense_s >>> res_s;
		err_new = '0;
		err_new[readout_pkg::ERR_OVERSPEED] = ((quad_prev ^ quad_cur) == 2'h2);
		err_new[readout_pkg::ERR_WEAK] = (strength < readout_pkg::WEAK_LEVEL);
		err_new[readout_pkg::ERR_EXT_LSB +: 2] = err_ext;
		// a fresh error wins over the reset that clears the flags
		err_d = (reset_evt ? 4'h0 : err_q) | err_new;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			en_prev_q <= 1'b1;
			prev_phase_q <= '0;
			period_q <= '0;
			pos_q <= '0;
			err_q <= '0;
		end else begin
			en_prev_q <= en_prev_d;
			prev_phase_q <= prev_phase_d;
			period_q <= period_d;
			pos_q <= pos_d;
			err_q <= err_d;
		end
	end

	// ----------------------------------------------------------------
	// sample history: the tap lines up with the sample before the strobe
	// ----------------------------------------------------------------
	logic [readout_pkg::POS_W-1:0] hist_q [readout_pkg::HIST_DEPTH];
	logic [readout_pkg::POS_W-1:0] hist_d [readout_pkg::HIST_DEPTH];

	// costs a 19-deep shift line but keeps the data age fixed whatever the bus does
	always_comb begin
		hist_d[0] = pos_q;
		for (int i = 1; i < readout_pkg::HIST_DEPTH; i++) begin
			hist_d[i] = hist_q[i-1];
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < readout_pkg::HIST_DEPTH; i++) begin
				hist_q[i] <= '0;
			end
		end else begin
			hist_q <= hist_d;
		end
	end

	// ----------------------------------------------------------------
	// capture and delayed release to the position register
	// ----------------------------------------------------------------
	logic [readout_pkg::POS_W-1:0] cap_q, cap_d, hold_q, hold_d;
	logic [DVC_W-1:0] dv_cnt_q, dv_cnt_d;
	logic valid_q, valid_d;

	// the held word changes only when the countdown ends or a module reset clears it, never mid-read
	always_comb begin
		cap_d = cap_q;
		hold_d = hold_q;
		dv_cnt_d = dv_cnt_q;
		valid_d = valid_q;
		if (capture_evt) begin
			cap_d = hist_q[readout_pkg::HIST_DEPTH-1];
			dv_cnt_d = DV_LOAD;
			valid_d = 1'b0;
		end else if (dv_cnt_q != '0) begin
			dv_cnt_d = dv_cnt_q - 1'b1;
			if (dv_cnt_q == 5'h01) begin
				hold_d = cap_q;
				valid_d = 1'b1;
			end
		end
		if (reset_evt) begin
			cap_d = '0;
			hold_d = '0;
			dv_cnt_d = '0;
			valid_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cap_q <= '0;
			hold_q <= '0;
			dv_cnt_q <= '0;
			valid_q <= 1'b0;
		end else begin
			cap_q <= cap_d;
			hold_q <= hold_d;
			dv_cnt_q <= dv_cnt_d;
			valid_q <= valid_d;
		end
	end

	// ----------------------------------------------------------------
	// register readout onto the data lines
	// ----------------------------------------------------------------
	logic [readout_pkg::POS_W-1:0] out_q, out_d, status_word;
	logic oe_n_q, oe_n_d, rst_pulse_q;

	always_comb begin
		status_word = '0;
		status_word[readout_pkg::ST_COS_LSB +: readout_pkg::ADC_W] = cos_sample;
		status_word[readout_pkg::ST_SIN_LSB +: readout_pkg::ADC_W] = sin_sample;
		status_word[readout_pkg::ST_STR_LSB +: readout_pkg::STR_W] = strength;
		status_word[readout_pkg::ST_ERR_LSB +: 4] = err_q;
		status_word[readout_pkg::ST_SW_LSB +: 3] = {dir_s, res_s};
		unique case (reg_s)
			readout_pkg::REG_POSITION: out_d = hold_q;
			readout_pkg::REG_STATUS: out_d = status_word;
			readout_pkg::REG_MODRESET: out_d = '0;
			readout_pkg::REG_SPARE: out_d = '0;
		endcase
		oe_n_d = ~(~enable_s & mine);
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			out_q <= '0;
			oe_n_q <= 1'b1;
			rst_pulse_q <= 1'b0;
		end else begin
			out_q <= out_d;
			oe_n_q <= oe_n_d;
			rst_pulse_q <= reset_evt;
		end
	end

	assign bus.board_data = out_q;
	assign bus.board_oe_n = oe_n_q;
	assign module_reset = rst_pulse_q;
	assign position_valid = valid_q;
endmodule

// ---- readout_pkg.sv ----
// shared constants for the parallel position readout bus and its two ends
package readout_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 5;
	localparam int SYNC_LAT = 3;
	localparam int TPD_NS = 80;
	localparam int PD_CYC = TPD_NS / CLK_NS;
	localparam int HIST_DEPTH = PD_CYC + SYNC_LAT;
	localparam int TDV_NS = 150;
	localparam int TDV_CYC = TDV_NS / CLK_NS;
	localparam int TOE_NS = 50;
	localparam int TOE_CYC = (TOE_NS + CLK_NS - 1) / CLK_NS;
	localparam int TSU_NS = 10;
	localparam int TSU_CYC = (TSU_NS + CLK_NS - 1) / CLK_NS;
	localparam int THD_NS = 10;
	localparam int THD_CYC = (THD_NS + CLK_NS - 1) / CLK_NS;
	localparam int TSP_NS = 100;
	localparam int TSP_CYC = (TSP_NS + CLK_NS - 1) / CLK_NS;
	localparam int TZV_NS = 35;
	localparam int TZV_CYC = TZV_NS / CLK_NS;
	localparam int RD_CYC = TZV_CYC + 2 * SYNC_LAT + 1;
	// ----------------------------------------------------------------
	// bus shape and register selection
	// ----------------------------------------------------------------
	localparam int AXIS_W = 3;
	localparam int REG_W = 2;
	localparam int POS_W = 36;
	localparam int PHASE_W = 12;
	localparam int PERIOD_W = POS_W - PHASE_W;
	localparam int ADC_W = 10;
	localparam int STR_W = 8;
	localparam logic [AXIS_W-1:0] BCAST_AXIS = 3'h0;
	localparam logic [REG_W-1:0] REG_POSITION = 2'h0;
	localparam logic [REG_W-1:0] REG_STATUS = 2'h1;
	localparam logic [REG_W-1:0] REG_MODRESET = 2'h2;
	localparam logic [REG_W-1:0] REG_SPARE = 2'h3;
	// status word fields
	localparam int ST_COS_LSB = 0;
	localparam int ST_SIN_LSB = 10;
	localparam int ST_STR_LSB = 20;
	localparam int ST_ERR_LSB = 28;
	localparam int ST_SW_LSB = 32;
	localparam int ERR_OVERSPEED = 0;
	localparam int ERR_WEAK = 1;
	localparam int ERR_EXT_LSB = 2;
	localparam logic [STR_W-1:0] WEAK_LEVEL = 8'h20;
	// ----------------------------------------------------------------
	// controller registers on apb
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_CMD = 12'h000;
	localparam logic [11:0] OFS_STAT = 12'h004;
	localparam logic [11:0] OFS_DLO = 12'h008;
	localparam logic [11:0] OFS_DHI = 12'h00c;
	localparam int CMD_AXIS_LSB = 0;
	localparam int CMD_REG_LSB = 3;
	localparam int STAT_BUSY = 0;
	localparam int STAT_VALID = 1;
endpackage

// ---- readout_bus_if.sv ----
// parallel readout bus joining the controller end and one axis board
`timescale 1ns/1ps
interface readout_bus_if;
	logic [readout_pkg::AXIS_W-1:0] sel_axis;
	logic [readout_pkg::REG_W-1:0] sel_reg;
	logic enable_n;
	logic [readout_pkg::POS_W-1:0] board_data;
	logic board_oe_n;
	logic [readout_pkg::POS_W-1:0] data_line;

	// released lines read as zero, no board drives them
	assign data_line = board_oe_n ? '0 : board_data;

	modport board (
		input sel_axis,
		input sel_reg,
		input enable_n,
		output board_data,
		output board_oe_n
	);
	modport host (
		output sel_axis,
		output sel_reg,
		output enable_n,
		input data_line
	);
endinterface

// ---- pin_sync.sv ----
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q, out_d;

	// stage one feeds stage two only, so no logic sees a metastable value
	always_comb begin
		out_d = (s2_q == s3_q) ? s3_q : out_q;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			out_q <= INIT;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= out_d;
		end
	end

	assign q = out_q;
endmodule

// ---- bus_controller.sv ----
// controller end: apb command registers driving strobed accesses on the readout bus
`timescale 1ns/1ps
module bus_controller (
	input wire logic clk_sys,
	input wire logic sys_rst,
	readout_bus_if.host bus,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	// ----------------------------------------------------------------
	// data line synchroniser
	// ----------------------------------------------------------------
	logic [readout_pkg::POS_W-1:0] data_s;

	pin_sync #(.WIDTH(readout_pkg::POS_W), .INIT({readout_pkg::POS_W{1'b0}})) data_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin(bus.data_line),
		.q(data_s)
	);

	// ----------------------------------------------------------------
	// access sequencer
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {IDLE, SETUP, STROBE, HOLD} seq_t;
	seq_t st_q, st_d;
	logic [5:0] cnt_q, cnt_d, gap_q, gap_d, need_q, need_d;
	logic [readout_pkg::AXIS_W-1:0] axis_q, axis_d;
	logic [readout_pkg::REG_W-1:0] reg_q, reg_d;
	logic [readout_pkg::POS_W-1:0] data_q, data_d;
	logic valid_q, valid_d, launch, is_read;
	logic [31:0] rd_d, rd_q;

	assign launch = psel && penable && pwrite && (paddr == readout_pkg::OFS_CMD) && (st_q == IDLE);
	assign is_read = (axis_q != readout_pkg::BCAST_AXIS);

	// gap counts from the last strobe start so the spacing holds across commands
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		axis_d = axis_q;
		reg_d = reg_q;
		data_d = data_q;
		valid_d = valid_q;
		need_d = need_q;
		gap_d = (gap_q == 6'h3f) ? gap_q : gap_q + 1'b1;
		unique case (st_q)
			IDLE: begin
				if (launch) begin
					axis_d = pwdata[readout_pkg::CMD_AXIS_LSB +: readout_pkg::AXIS_W];
					reg_d = pwdata[readout_pkg::CMD_REG_LSB +: readout_pkg::REG_W];
					cnt_d = 6'(readout_pkg::TSU_CYC);
					st_d = SETUP;
				end
			end
			SETUP: begin
				if (cnt_q > 6'h01) begin
					cnt_d = cnt_q - 1'b1;
				end else if (gap_q >= need_q) begin
					gap_d = '0;
					// after a broadcast the next strobe waits for the held word
					need_d = is_read ? 6'(readout_pkg::TSP_CYC) : 6'(readout_pkg::TDV_CYC);
					cnt_d = is_read ? 6'(readout_pkg::RD_CYC) : 6'(readout_pkg::TOE_CYC);
					st_d = STROBE;
				end
			end
			STROBE: begin
				cnt_d = cnt_q - 1'b1;
				if (cnt_q == 6'h01) begin
					if (is_read) begin
						data_d = data_s;
						valid_d = 1'b1;
					end
					cnt_d = 6'(readout_pkg::THD_CYC);
					st_d = HOLD;
				end
			end
			HOLD: begin
				cnt_d = cnt_q - 1'b1;
				if (cnt_q == 6'h01) begin
					st_d = IDLE;
				end
			end
		endcase
		if (launch) begin
			valid_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= IDLE;
			cnt_q <= '0;
			gap_q <= 6'h3f;
			need_q <= '0;
			axis_q <= '0;
			reg_q <= '0;
			data_q <= '0;
			valid_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			gap_q <= gap_d;
			need_q <= need_d;
			axis_q <= axis_d;
			reg_q <= reg_d;
			data_q <= data_d;
			valid_q <= valid_d;
		end
	end

	assign bus.sel_axis = axis_q;
	assign bus.sel_reg = reg_q;
	assign bus.enable_n = (st_q != STROBE);

	// ----------------------------------------------------------------
	// apb slave: read data registered in the setup cycle, zero wait states
	// ----------------------------------------------------------------
	always_comb begin
		rd_d = rd_q;
		if (psel && !penable) begin
			rd_d = 32'h0000_0000;
			if (paddr == readout_pkg::OFS_STAT) begin
				rd_d[readout_pkg::STAT_BUSY] = (st_q != IDLE);
				rd_d[readout_pkg::STAT_VALID] = valid_q;
			end else if (paddr == readout_pkg::OFS_DLO) begin
				rd_d = data_q[31:0];
			end else if (paddr == readout_pkg::OFS_DHI) begin
				rd_d[readout_pkg::POS_W-33:0] = data_q[readout_pkg::POS_W-1:32];
			end else if (paddr == readout_pkg::OFS_CMD) begin
				rd_d[readout_pkg::CMD_AXIS_LSB +: readout_pkg::AXIS_W] = axis_q;
				rd_d[readout_pkg::CMD_REG_LSB +: readout_pkg::REG_W] = reg_q;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rd_q <= '0;
		end else begin
			rd_q <= rd_d;
		end
	end

	assign prdata = rd_q;
	assign pready = 1'b1;
	assign pslverr = psel && penable && (paddr != readout_pkg::OFS_CMD) &&
		(paddr != readout_pkg::OFS_STAT) && (paddr != readout_pkg::OFS_DLO) &&
		(paddr != readout_pkg::OFS_DHI);
endmodule

// ---- readout_bus_props.sv ----
// concurrent checks on the readout bus between controller end and board end
`timescale 1ns/1ps
module readout_bus_props (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [2:0] sel_axis,
	input wire logic [1:0] sel_reg,
	input wire logic enable_n,
	input wire logic [35:0] board_data,
	input wire logic board_oe_n,
	input wire logic [35:0] data_line
);
	logic en_q, en_d, cap_q, cap_d;
	logic [7:0] low_q, low_d, gap_q, gap_d;
	// ----------------------------------------------------------------
	// strobe length and spacing counters
	// ----------------------------------------------------------------
	// gap saturates so a long idle never wraps into a false short gap
	always_comb begin
		en_d = enable_n;
		low_d = enable_n ? 8'h00 : low_q + 8'h01;
		gap_d = (gap_q == 8'hff) ? gap_q : gap_q + 8'h01;
		cap_d = cap_q;
		if (en_q && !enable_n) begin
			gap_d = 8'h01;
			cap_d = (sel_axis == 3'h0) && (sel_reg == 2'h0);
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			en_q <= 1'b1;
			cap_q <= 1'b0;
			low_q <= 8'h00;
			gap_q <= 8'hff;
		end else begin
			en_q <= en_d;
			cap_q <= cap_d;
			low_q <= low_d;
			gap_q <= gap_d;
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	sequence s_low_min;
		(!enable_n) [*8] ##1 (!enable_n) [*2];
	endsequence
	sequence s_released;
		##5 board_oe_n;
	endsequence
	property p_strobe_min;
		$fell(enable_n) |-> s_low_min;
	endproperty
	property p_strobe_len;
		$rose(enable_n) |-> low_q == ((sel_axis == 3'h0) ? 8'h0a : 8'h0e);
	endproperty
	property p_spacing;
		$fell(enable_n) |-> gap_q >= (cap_q ? 8'h1e : 8'h14);
	endproperty
	property p_addr_held;
		!enable_n |-> $stable(sel_axis) && $stable(sel_reg);
	endproperty
	property p_drive_window;
		!board_oe_n |-> !$past(enable_n, 5);
	endproperty
	property p_release;
		$rose(enable_n) |-> s_released;
	endproperty
	property p_no_bcast_drive;
		!board_oe_n |-> $past(sel_axis, 5) != 3'h0;
	endproperty
	property p_spare_zero;
		!board_oe_n && $past(sel_reg, 5) == 2'h3 |-> data_line == 36'h0;
	endproperty
	property p_status_top;
		!board_oe_n && $past(sel_reg, 5) == 2'h1 |-> data_line[35] == 1'b0;
	endproperty
	property p_data_held;
		!board_oe_n && !$past(board_oe_n) |-> $stable(board_data);
	endproperty
	a_strobe_min: assert property (p_strobe_min) else $error("strobe too short");
	a_strobe_len: assert property (p_strobe_len) else $error("strobe length off");
	a_spacing: assert property (p_spacing) else $error("strobes too close");
	a_addr_held: assert property (p_addr_held) else $error("address moved");
	a_drive_window: assert property (p_drive_window) else $error("drive unstrobed");
	a_release: assert property (p_release) else $error("bus not released");
	a_no_bcast_drive: assert property (p_no_bcast_drive) else $error("bcast drive");
	a_spare_zero: assert property (p_spare_zero) else $error("spare not zero");
	a_status_top: assert property (p_status_top) else $error("status bit 35 set");
	a_data_held: assert property (p_data_held) else $error("data moved");
endmodule

// ---- tb_parallel_position_readout.sv ----
// self-checking bench: controller and axis board joined, driven over apb
`timescale 1ns/1ps
`define CHK(a, e, m) begin comparisons++; if ((a) !== (e)) begin \
	err_count++; $display("FAIL %0t %s", $time, m); end end
module tb_parallel_position_readout;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, r;
	logic pready, pslverr, module_reset, position_valid, e;
	logic [9:0] cos_sample = 10'h155;
	logic [9:0] sin_sample = 10'h2aa;
	logic [11:0] phase_fine = 12'h100;
	logic [7:0] strength = 8'h40;
	logic [1:0] err_ext = 2'h0;
	logic [2:0] sw_addr = 3'h1;
	logic [1:0] sw_res = 2'h0;
	logic sw_dir = 1'b0;
	logic [35:0] word;
	int err_count = 0;
	int comparisons = 0;
	int resets = 0;
	int n;
	logic [1:0] res_tab [4] = '{2'h1, 2'h3, 2'h0, 2'h0};
	logic dir_tab [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
	logic [35:0] pos_tab [4] = '{36'h100, 36'h040, 36'hffffffe00, 36'h200};
	readout_bus_if readout_bus_if_i ();
	bus_controller bus_controller_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.bus(readout_bus_if_i.host), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	axis_board axis_board_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.bus(readout_bus_if_i.board), .cos_sample(cos_sample), .sin_sample(sin_sample),
		.phase_fine(phase_fine), .strength(strength), .err_ext(err_ext),
		.sw_addr(sw_addr), .sw_res(sw_res), .sw_dir(sw_dir),
		.module_reset(module_reset), .position_valid(position_valid));
	readout_bus_props readout_bus_props_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.sel_axis(readout_bus_if_i.sel_axis), .sel_reg(readout_bus_if_i.sel_reg),
		.enable_n(readout_bus_if_i.enable_n), .board_data(readout_bus_if_i.board_data),
		.board_oe_n(readout_bus_if_i.board_oe_n), .data_line(readout_bus_if_i.data_line));
	// ----------------------------------------------------------------
	// clock, pulse counter and tasks
	// ----------------------------------------------------------------
	always #2.5 clk_sys = ~clk_sys;
	// a one-cycle pulse is seen at exactly one edge
	always @(posedge clk_sys) if (module_reset === 1'b1) resets++;
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// one apb transfer, held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 64);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 64) begin
			err_count++;
			test_done();
		end
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		do begin
			apb(1'b0, readout_pkg::OFS_STAT, 32'h0);
			k++;
		end while (r[readout_pkg::STAT_BUSY] !== 1'b0 && k < 100);
		if (k >= 100) begin
			err_count++;
			test_done();
		end
	endtask
	task automatic cmd(input logic [2:0] ax, input logic [1:0] rg);
		apb(1'b1, readout_pkg::OFS_CMD, {27'h0, rg, ax});
		wait_idle();
	endtask
	task automatic rd(input logic [2:0] ax, input logic [1:0] rg);
		cmd(ax, rg);
		`CHK(r[readout_pkg::STAT_VALID], 1'b1, "read not valid")
		apb(1'b0, readout_pkg::OFS_DLO, 32'h0);
		word[31:0] = r;
		apb(1'b0, readout_pkg::OFS_DHI, 32'h0);
		word[35:32] = r[3:0];
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(3'h1, readout_pkg::REG_STATUS);
		`CHK(word, {8'h00, 8'h40, 10'h2aa, 10'h155}, "status word")
		$display("test status done");
		// sample moves just before the strobe, so the older value must be held
		phase_fine <= 12'h200;
		apb(1'b1, readout_pkg::OFS_CMD, 32'h0);
		n = 0;
		while (position_valid !== 1'b1 && n < 60) begin
			@(posedge clk_sys);
			n++;
		end
		`CHK(n >= 31 && n <= 35, 1'b1, "capture latency")
		if (n >= 60) test_done();
		wait_idle();
		rd(3'h1, readout_pkg::REG_POSITION);
		`CHK(word, 36'h100, "sample age")
		$display("test capture done");
		for (int i = 0; i < 4; i++) begin
			sw_res <= res_tab[i];
			sw_dir <= dir_tab[i];
			// switch sync plus the history line must settle before the capture tap
			repeat (24) @(posedge clk_sys);
			cmd(3'h0, readout_pkg::REG_POSITION);
			rd(3'h1, readout_pkg::REG_POSITION);
			`CHK(word, pos_tab[i], "scaled position")
		end
		$display("test switches done");
		// four quadrant steps in a row cross one period boundary upward
		phase_fine <= 12'h600;
		@(posedge clk_sys);
		phase_fine <= 12'ha00;
		@(posedge clk_sys);
		phase_fine <= 12'he00;
		@(posedge clk_sys);
		phase_fine <= 12'h100;
		repeat (24) @(posedge clk_sys);
		cmd(3'h0, readout_pkg::REG_POSITION);
		rd(3'h1, readout_pkg::REG_POSITION);
		`CHK(word, 36'h000001100, "period wrap")
		$display("test wrap done");
		n = resets;
		rd(3'h1, readout_pkg::REG_MODRESET);
		`CHK(word, 36'h0, "reset register data")
		`CHK(resets - n == 1, 1'b1, "board reset pulse")
		rd(3'h1, readout_pkg::REG_POSITION);
		`CHK(word, 36'h0, "hold word cleared")
		err_ext <= 2'h1;
		strength <= 8'h10;
		repeat (4) @(posedge clk_sys);
		err_ext <= 2'h0;
		strength <= 8'h40;
		rd(3'h1, readout_pkg::REG_STATUS);
		`CHK(word, {8'h06, 8'h40, 10'h2aa, 10'h155}, "sticky errors")
		cmd(3'h0, readout_pkg::REG_MODRESET);
		`CHK(resets - n == 2, 1'b1, "broadcast reset pulse")
		rd(3'h1, readout_pkg::REG_STATUS);
		`CHK(word[31:28], 4'h0, "errors cleared")
		$display("test reset done");
		rd(3'h1, readout_pkg::REG_SPARE);
		`CHK(word, 36'h0, "spare register")
		apb(1'b0, 12'h010, 32'h0);
		`CHK({e, r}, {1'b1, 32'h0}, "unmapped offset")
		$display("test decode done");
		test_done();
	end
endmodule
